// ### hw/lnb_pkg.sv
// Shared constants, field layouts and state types for the antenna supply
// protection and diagnostic controller.
// Assumes a single 250 MHz system clock and a synchronous active-high reset.
//
// Operation
// R01 - Envelope mode: external select clear, tone enabled.
// R02 - Tone starts about 6 us after rise.
// R03 - Tone stops 15 to 60 us after fall.
// R04 - Four level bits select output voltage.
// R05 - Three diagnostic flags, zero without failure.
// R06 - Flags latch until cause gone and read.
// R07 - Lockout ignores commands, clears all data bits.
// R08 - Leaving lockout makes command port operational.
// R09 - Low supply sets flag, drives fault low.
// R10 - Limit select picks static clamp or pulsed.
// R11 - Pulsed: 90 ms on, 900 ms off, flag.
// R12 - Retry on window; repeat off while overloaded.
// R13 - Static clamp sets flag at clamp limit.
// R14 - Host starts capacitive loads in static mode.
// R15 - Overload restart one: clear level bits.
// R16 - Overload restart zero: re-enable automatically.
// R17 - Overheat shuts converter and regulator, sets flag.
// R18 - Overheat restart one: clear level bits.
// R19 - Overheat restart zero: re-enable automatically.
// R20 - Continuous tone: envelope high, tone bit alone.
// R21 - Window durations come from counted clock cycles.

package lnb_pkg;

  // Clock period of clk_sys in nanoseconds.
  localparam int CLK_PERIOD_NS = 4;

  // Envelope tone start delay, as a time and as a cycle count.
  localparam int TONE_ON_DLY_NS = 6000;
  localparam int TONE_ON_CYC = TONE_ON_DLY_NS / CLK_PERIOD_NS;

  // Envelope tone stop window; the least time is rounded up.
  localparam int TONE_OFF_MIN_NS = 15000;
  localparam int TONE_OFF_MAX_NS = 60000;
  localparam int TONE_OFF_CYC =
    (TONE_OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the tone delay counter.
  localparam int TONE_CNT_W = 12;

  // Pulsed overload windows in milliseconds and in cycles.
  localparam int ON_WIN_MS = 90;
  localparam int OFF_WIN_MS = 900;
  localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam int ON_WIN_CYC = ON_WIN_MS * CYC_PER_MS;
  localparam int OFF_WIN_CYC = OFF_WIN_MS * CYC_PER_MS;

  // Width of the window timer, enough for the off window.
  localparam int TMR_W = 28;

  // Output level field width and the code that disables the output.
  localparam int LEVEL_W = 4;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF = 4'h0;

  // Control register image written by the host.
  typedef struct packed {
    logic [LEVEL_W-1:0] output_level_bits; // Output voltage code.
    logic external_tone_select;            // Pin carries the 22 kHz wave.
    logic tone_on_bit;                     // Tone enable.
    logic pulsed_limit_select;             // 1 static clamp, 0 pulsed.
    logic overload_restart_mode;           // 1 needs a rewrite of levels.
    logic overheat_restart_mode;           // 1 needs a rewrite of levels.
  } lnb_cfg_t;

  // Diagnostic status register image.
  typedef struct packed {
    logic overheat_flag;   // Junction overtemperature seen.
    logic overload_flag;   // Output overload seen.
    logic supply_low_flag; // Input supply below minimum seen.
  } lnb_diag_t;

  // Pulsed overload protection sequence.
  typedef enum logic [1:0] {
    OL_IDLE,  // Normal operation.
    OL_HOLD,  // First on window while overloaded.
    OL_OFF,   // Output shut down.
    OL_RETRY  // Output resumed for one on window.
  } lnb_ol_state_t;

endpackage

// ### hw/lnb_win_timer.sv
// One-shot down counter that times the overload on and off windows.
// Assumes the loader issues a one-cycle load pulse with a nonzero count.

`timescale 1ns/10ps

module lnb_win_timer
  import lnb_pkg::*;
#(
  parameter int W = TMR_W // Counter width.
)
(
  input wire logic clk_sys,           // System clock.
  input wire logic srst,              // Synchronous reset, active high.
  input wire logic load,              // Start a window, one-cycle pulse.
  input wire logic [W-1:0] load_val,  // Window length in cycles.
  output logic busy,                  // Window running.
  output logic done                   // Window ended, one-cycle pulse.
);

  // Complete state of the timer.
  typedef struct packed {
    logic [W-1:0] cnt; // Cycles left minus one.
    logic busy;        // Counting.
    logic done;        // End pulse.
  } lnb_tmr_t;

  lnb_tmr_t st_ff;  // Registered state.
  lnb_tmr_t nxt_st; // Next state.

  ////////////////////////////////////////////////////////////////////////////

  // A load restarts the count at once, so a new window never inherits an
  // old remainder.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (load)
    begin
      nxt_st.cnt = load_val - W'(1); // [R21]
      nxt_st.busy = 1'b1;
    end
    else if (st_ff.busy)
    begin
      // The last cycle of the window raises the end pulse.
      if (st_ff.cnt == '0)
      begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt - W'(1);
      end
    end
  end

  // Registers the timer state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;

endmodule

// ### hw/lnb_protect_diag_ctrl.sv
// Control logic of the antenna supply device: tone gating, diagnostic
// flags, pulsed overload timing, restart policies and lockout clearing.
// Assumes the analog detectors and the envelope pin are asynchronous, and
// that a serial front end delivers one-cycle write and read strobes.

`timescale 1ns/10ps

module lnb_protect_diag_ctrl
  import lnb_pkg::*;
#(
  parameter int ON_CYC = ON_WIN_CYC,  // On window length in cycles.
  parameter int OFF_CYC = OFF_WIN_CYC // Off window length in cycles.
)
(
  input wire logic clk_sys,             // System clock, 250 MHz.
  input wire logic srst,                // Synchronous reset, active high.
  input wire logic envelope_input,      // Envelope or external tone pin.
  input wire logic undervoltage_lock,   // Supply below lockout level.
  input wire logic low_supply_detect,   // Supply below minimum.
  input wire logic overload_detect,     // Output current at its limit.
  input wire logic overheat_detect,     // Junction too hot.
  input wire logic cfg_wr,              // Control write, one-cycle pulse.
  input wire lnb_cfg_t cfg_wdata,       // Control value to write.
  input wire logic stat_rd,             // Status read, one-cycle pulse.
  output lnb_cfg_t cfg_q,               // Control register contents.
  output lnb_diag_t diag_status,        // Diagnostic status register.
  output logic [LEVEL_W-1:0] output_level_bits, // Selected output level.
  output logic tone_out_en,             // Gate of the internal tone.
  output logic boost_en,                // Step-up converter enable.
  output logic ldo_en,                  // Linear regulator enable.
  output logic static_clamp_en,         // Static current clamp chosen.
  output logic fault_out_n,             // Fault pin, active low.
  output logic serial_ready             // Command port operational.
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // Complete state of the controller in one record.
  typedef struct packed {
    logic env_m;                      // Envelope pin, first stage.
    logic env_s;                      // Envelope pin, synchronised.
    logic uv_m;                       // Lockout detector, first stage.
    logic uv_s;                       // Lockout detector, synchronised.
    logic lp_m;                       // Low supply, first stage.
    logic lp_s;                       // Low supply, synchronised.
    logic ol_m;                       // Overload, first stage.
    logic ol_s;                       // Overload, synchronised.
    logic ot_m;                       // Overheat, first stage.
    logic ot_s;                       // Overheat, synchronised.
    logic ol_d;                       // Overload one cycle earlier.
    logic ot_d;                       // Overheat one cycle earlier.
    lnb_cfg_t cfg;                    // Control register.
    lnb_diag_t diag;                  // Sticky diagnostic flags.
    logic [TONE_CNT_W-1:0] tcnt;      // Tone delay counter.
    logic tone_en;                    // Tone gate.
    logic boost_en;                   // Converter enable.
    logic ldo_en;                     // Regulator enable.
    logic fault_n;                    // Fault pin level.
    logic ready;                      // Command port open.
    lnb_ol_state_t ol_state;          // Pulsed overload sequence.
  } lnb_state_t;

  lnb_state_t st_ff;  // Registered state.
  lnb_state_t nxt_st; // Next state.

  logic tmr_load;             // Start a window.
  logic [TMR_W-1:0] tmr_val;  // Length of that window.
  logic tmr_busy;             // Window running.
  logic tmr_done;             // Window ended.
  logic ol_set;               // Overload flag set event.
  logic ol_cause;             // Overload cause still present.
  logic ol_end;               // Overload over, restart policy applies.
  logic ot_end;               // Overheat over, restart policy applies.

  // Window lengths at the timer's width.
  localparam logic [TMR_W-1:0] ON_LEN = TMR_W'(ON_CYC);
  localparam logic [TMR_W-1:0] OFF_LEN = TMR_W'(OFF_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Window timer.

  // Times the on and off windows of the pulsed overload protection.
  lnb_win_timer #(
    .W(TMR_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(tmr_load),
    .load_val(tmr_val),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Computes the whole next state from the registered state and inputs.
  always_comb
  begin
    nxt_st = st_ff;
    tmr_load = 1'b0;
    tmr_val = ON_LEN;
    ol_set = 1'b0;
    ol_end = 1'b0;

    // Two-stage synchronisers; only the second stage is read below.
    nxt_st.env_m = envelope_input;
    nxt_st.env_s = st_ff.env_m;
    nxt_st.uv_m = undervoltage_lock;
    nxt_st.uv_s = st_ff.uv_m;
    nxt_st.lp_m = low_supply_detect;
    nxt_st.lp_s = st_ff.lp_m;
    nxt_st.ol_m = overload_detect;
    nxt_st.ol_s = st_ff.ol_m;
    nxt_st.ot_m = overheat_detect;
    nxt_st.ot_s = st_ff.ot_m;
    nxt_st.ol_d = st_ff.ol_s;
    nxt_st.ot_d = st_ff.ot_s;

    // Pulsed protection runs only when the static clamp is not chosen.
    if (st_ff.cfg.pulsed_limit_select) // [R10]
    begin
      // Static clamp: the clamp holds the current, the flag records it.
      nxt_st.ol_state = OL_IDLE;
      if (st_ff.ol_s)
      begin
        ol_set = 1'b1; // [R13]
      end
      if (st_ff.ol_d && !st_ff.ol_s)
      begin
        ol_end = 1'b1;
      end
    end
    else
    begin
      unique case (st_ff.ol_state)
        OL_IDLE:
        begin
          // Overload found: keep supplying for one on window.
          if (st_ff.ol_s)
          begin
            nxt_st.ol_state = OL_HOLD; // [R11]
            tmr_load = 1'b1;
            tmr_val = ON_LEN; // [R21]
          end
        end
        OL_HOLD:
        begin
          // On window over: shut down and raise the flag together.
          if (tmr_done)
          begin
            nxt_st.ol_state = OL_OFF; // [R11]
            tmr_load = 1'b1;
            tmr_val = OFF_LEN;
            ol_set = 1'b1;
          end
        end
        OL_OFF:
        begin
          // Off window over: resume for a fresh on window.
          if (tmr_done)
          begin
            nxt_st.ol_state = OL_RETRY; // [R12]
            tmr_load = 1'b1;
            tmr_val = ON_LEN; // [R21]
          end
        end
        OL_RETRY:
        begin
          // Still overloaded at the end: cycle again, else resume.
          if (tmr_done)
          begin
            if (st_ff.ol_s)
            begin
              nxt_st.ol_state = OL_OFF; // [R12]
              tmr_load = 1'b1;
              tmr_val = OFF_LEN;
              ol_set = 1'b1;
            end
            else
            begin
              nxt_st.ol_state = OL_IDLE; // [R12]
              ol_end = 1'b1;
            end
          end
        end
      endcase
    end

    // The overload cause lasts while detected or while the cycle runs.
    ol_cause = st_ff.ol_s || (st_ff.ol_state != OL_IDLE);
    ot_end = st_ff.ot_d && !st_ff.ot_s;

    // Sticky flags: a set in the same cycle as a read wins over the clear,
    // and a read only clears a flag whose cause has gone.
    nxt_st.diag.overload_flag = ol_set ||
      (st_ff.diag.overload_flag && !(stat_rd && !ol_cause)); // [R06]
    nxt_st.diag.overheat_flag = st_ff.ot_s ||
      (st_ff.diag.overheat_flag && !(stat_rd && !st_ff.ot_s)); // [R17]
    nxt_st.diag.supply_low_flag = st_ff.lp_s ||
      (st_ff.diag.supply_low_flag && !(stat_rd && !st_ff.lp_s)); // [R09]

    // Control register: lockout clears it and blocks writes.
    if (st_ff.uv_s)
    begin
      nxt_st.cfg = '0; // [R07]
      nxt_st.ol_state = OL_IDLE;
    end
    else
    begin
      // Restart policies; with mode zero the levels stay and the output
      // comes back by itself.
      if (ol_end && st_ff.cfg.overload_restart_mode)
      begin
        nxt_st.cfg.output_level_bits = LEVEL_OFF; // [R15]
      end
      if (ot_end && st_ff.cfg.overheat_restart_mode)
      begin
        nxt_st.cfg.output_level_bits = LEVEL_OFF; // [R18]
      end
      // A host write lands after the policy clear, so a rewrite wins.
      if (cfg_wr)
      begin
        nxt_st.cfg = cfg_wdata; // [R04]
      end
    end
    nxt_st.ready = !st_ff.uv_s; // [R08]

    // Power enables: a zero level, lockout or heat stop the converter; the
    // off window also stops the regulator.
    nxt_st.boost_en = (nxt_st.cfg.output_level_bits != LEVEL_OFF) &&
      !st_ff.uv_s && !st_ff.ot_s; // [R17]
    nxt_st.ldo_en = nxt_st.boost_en &&
      (nxt_st.ol_state != OL_OFF); // [R16] [R19]
    nxt_st.fault_n = !nxt_st.diag.supply_low_flag; // [R09]

    // Tone gate.
    if (!st_ff.cfg.tone_on_bit)
    begin
      // Tone disabled: gate closed at once.
      nxt_st.tone_en = 1'b0; // [R20]
      nxt_st.tcnt = '0;
    end
    else if (st_ff.cfg.external_tone_select)
    begin
      // External wave: the pin drives the carrier gate directly.
      nxt_st.tone_en = st_ff.env_s;
      nxt_st.tcnt = '0;
    end
    else if (st_ff.env_s != st_ff.tone_en)
    begin
      // Envelope changed: wait out the start or stop delay first; a pin
      // that returns early restarts the count.
      if (st_ff.tcnt == (st_ff.tone_en ? TONE_CNT_W'(TONE_OFF_CYC - 1)
                                       : TONE_CNT_W'(TONE_ON_CYC - 1)))
      begin
        nxt_st.tone_en = st_ff.env_s; // [R01] [R02] [R03]
        nxt_st.tcnt = '0;
      end
      else
      begin
        nxt_st.tcnt = st_ff.tcnt + TONE_CNT_W'(1);
      end
    end
    else
    begin
      nxt_st.tcnt = '0;
    end
  end

  // Registers the whole controller state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_ff <= '0; // [R05]
      st_ff.fault_n <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken straight from registers.

  assign cfg_q = st_ff.cfg;
  assign diag_status = st_ff.diag;
  assign output_level_bits = st_ff.cfg.output_level_bits;
  assign tone_out_en = st_ff.tone_en;
  assign boost_en = st_ff.boost_en;
  assign ldo_en = st_ff.ldo_en;
  assign static_clamp_en = st_ff.cfg.pulsed_limit_select;
  assign fault_out_n = st_ff.fault_n;
  assign serial_ready = st_ff.ready;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Rising tone gate in envelope mode follows the full start delay.
  sequence s_env_rise;
    $rose(st_ff.tone_en) && !$past(st_ff.cfg.external_tone_select) &&
      $past(st_ff.cfg.tone_on_bit);
  endsequence

  sequence s_env_fall;
    $fell(st_ff.tone_en) && !$past(st_ff.cfg.external_tone_select) &&
      $past(st_ff.cfg.tone_on_bit);
  endsequence

  a_tone_start_delay: // [R02]
    assert property (s_env_rise |->
      $past(st_ff.tcnt) == TONE_CNT_W'(TONE_ON_CYC - 1))
    else $error("Envelope tone started without the start delay.");

  a_tone_stop_delay: // [R03]
    assert property (s_env_fall |->
      $past(st_ff.tcnt) == TONE_CNT_W'(TONE_OFF_CYC - 1))
    else $error("Envelope tone stopped without the stop delay.");

  a_tone_needs_bit: // [R01]
    assert property (!st_ff.cfg.tone_on_bit |=> !tone_out_en)
    else $error("Tone gate open with tone disabled.");

  a_level_write: // [R04]
    assert property (cfg_wr && !st_ff.uv_s |=>
      output_level_bits == $past(cfg_wdata.output_level_bits))
    else $error("Written output level not taken.");

  // A set overload flag whose cause remains or that sees no read.
  sequence s_flag_held;
    diag_status.overload_flag && (ol_cause || !stat_rd);
  endsequence

  a_flag_hold: // [R06]
    assert property (s_flag_held |=> diag_status.overload_flag)
    else $error("Overload flag dropped while its cause remained.");

  a_undervoltage_lock_clear: // [R07]
    assert property (st_ff.uv_s |=> cfg_q == '0 && !boost_en && !ldo_en)
    else $error("Data bits not cleared under lockout.");

  a_undervoltage_lock_ready: // [R08]
    assert property ($fell(st_ff.uv_s) |=> serial_ready)
    else $error("Command port not opened after lockout.");

  a_low_fault: // [R09]
    assert property (st_ff.lp_s |=> diag_status.supply_low_flag &&
      !fault_out_n)
    else $error("Low supply not flagged on the fault pin.");

  a_off_window: // [R11]
    assert property (st_ff.ol_state == OL_HOLD && tmr_done |=>
      st_ff.ol_state == OL_OFF && diag_status.overload_flag ##1 !ldo_en)
    else $error("Off window did not shut output and set flag.");

  a_window_timer: // [R21]
    assert property (st_ff.ol_state != OL_IDLE |-> tmr_busy || tmr_done)
    else $error("Pulsed sequence active with no window running.");

  a_static_flag: // [R13]
    assert property (st_ff.cfg.pulsed_limit_select && st_ff.ol_s |=>
      diag_status.overload_flag && st_ff.ol_state == OL_IDLE)
    else $error("Static clamp overload not flagged.");

  a_ol_restart_clr: // [R15]
    assert property (ol_end && st_ff.cfg.overload_restart_mode &&
      !cfg_wr && !st_ff.uv_s |=> output_level_bits == LEVEL_OFF)
    else $error("Level bits kept after overload in restart mode one.");

  a_heat_shutdown: // [R17]
    assert property (st_ff.ot_s |=> !boost_en && !ldo_en &&
      diag_status.overheat_flag)
    else $error("Overheat did not shut down the power stages.");

  a_heat_restart_clr: // [R18]
    assert property (ot_end && st_ff.cfg.overheat_restart_mode &&
      !cfg_wr && !st_ff.uv_s |=> output_level_bits == LEVEL_OFF)
    else $error("Level bits kept after overheat in restart mode one.");

endmodule

// ### sim/lnb_host_model.sv
// Host model: writes the control word, reads status, drives the envelope.
// Assumes the bench calls one task at a time from its main sequence.

`timescale 1ns/10ps

module lnb_host_model
  import lnb_pkg::*;
(
  input wire logic clk_sys, // System clock.
  output logic cfg_wr, // Control write strobe.
  output lnb_cfg_t cfg_wdata, // Control word.
  output logic stat_rd, // Status read strobe.
  output logic envelope_input // Envelope or wave pin.
);
  // All strobes start idle.
  initial
  begin
    cfg_wr = 1'h0;
    cfg_wdata = '0;
    stat_rd = 1'h0;
    envelope_input = 1'h0;
  end

  // One-cycle write; released data shows its inverse, not the old word.
  task automatic write_cfg(input lnb_cfg_t v);
    @(negedge clk_sys);
    cfg_wdata = v;
    cfg_wr = 1'h1;
    @(negedge clk_sys);
    cfg_wr = 1'h0;
    cfg_wdata = ~v;
  endtask

  // One-cycle status read.
  task automatic read_stat();
    @(negedge clk_sys);
    stat_rd = 1'h1;
    @(negedge clk_sys);
    stat_rd = 1'h0;
  endtask

  // Moves the envelope pin on a falling edge.
  task automatic set_env(input logic lvl);
    @(negedge clk_sys);
    envelope_input = lvl;
  endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the supply protection and diagnostic block.
// Assumes short window parameters so the pulsed cycle runs quickly.

`timescale 1ns/10ps

`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb
  import lnb_pkg::*;
;
  localparam int ON_T = 20; // Short on window.
  localparam int OFF_T = 50; // Short off window.
  logic clk_sys = 1'h0; // System clock.
  logic srst = 1'h1; // Reset.
  logic uv = 1'h0; // Lockout detector.
  logic lsd = 1'h0; // Low supply detector.
  logic ol = 1'h0; // Overload detector.
  logic oh = 1'h0; // Overheat detector.
  logic cfg_wr, stat_rd, envelope_input; // Host side.
  lnb_cfg_t cfg_wdata, cfg_q, w; // Control words.
  lnb_diag_t diag_status; // Flags.
  logic [3:0] output_level_bits; // Level seen.
  logic tone_out_en, boost_en, ldo_en, static_clamp_en;
  logic fault_out_n, serial_ready; // Fault pin and port state.
  logic [31:0] r; // Random draw.
  int miscompares = 0; // Mismatch count.
  int n_tests = 0; // Comparison count.
  int seed = 32'h30c1_cd4e; // Fixed seed keeps runs repeatable.

  // Clock of 4 ns.
  always #2 clk_sys = ~clk_sys;

  lnb_host_model u_host (.clk_sys(clk_sys), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .stat_rd(stat_rd),
    .envelope_input(envelope_input));

  lnb_protect_diag_ctrl #(.ON_CYC(ON_T), .OFF_CYC(OFF_T)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .envelope_input(envelope_input),
    .undervoltage_lock(uv), .low_supply_detect(lsd),
    .overload_detect(ol), .overheat_detect(oh), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .stat_rd(stat_rd), .cfg_q(cfg_q),
    .diag_status(diag_status), .output_level_bits(output_level_bits),
    .tone_out_en(tone_out_en), .boost_en(boost_en), .ldo_en(ldo_en),
    .static_clamp_en(static_clamp_en), .fault_out_n(fault_out_n),
    .serial_ready(serial_ready));

  // Waits a number of falling edges.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Expected regulator state for a written word with no fault present.
  function automatic logic exp_on(input lnb_cfg_t c);
    return c.output_level_bits != 4'h0;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial
  begin
    #80000;
    miscompares++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    cyc(5);
    `CHK("rst_fault", 1'h1, fault_out_n)
    `CHK("rst_diag", 3'h0, diag_status)
    srst = 1'h0;
    cyc(3);
    `CHK("ready", 1'h1, serial_ready)
    // Random control words reach the register unchanged.
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      w = r[8:0];
      u_host.write_cfg(w);
      cyc(1);
      `CHK("cfg_q", w, cfg_q)
      `CHK("level", w.output_level_bits, output_level_bits)
      `CHK("ldo", exp_on(w), ldo_en)
      `CHK("clamp", w.pulsed_limit_select, static_clamp_en)
    end
    $display("test random_cfg done");
    // Low supply flag sticks through a read while the cause persists.
    lsd = 1'h1;
    cyc(5);
    `CHK("low_flag", 1'h1, diag_status.supply_low_flag)
    `CHK("fault_n", 1'h0, fault_out_n)
    u_host.read_stat();
    cyc(2);
    `CHK("low_held", 1'h1, diag_status.supply_low_flag)
    lsd = 1'h0;
    cyc(5);
    `CHK("low_stick", 1'h1, diag_status.supply_low_flag)
    u_host.read_stat();
    cyc(2);
    `CHK("low_clr", 1'h0, diag_status.supply_low_flag)
    `CHK("fault_rel", 1'h1, fault_out_n)
    $display("test low_supply done");
    // Overheat under both restart policies.
    for (int m = 0; m < 2; m++)
    begin
      w = {4'h5, 4'h0, m[0]};
      u_host.write_cfg(w);
      oh = 1'h1;
      cyc(5);
      `CHK("ot_flag", 1'h1, diag_status.overheat_flag)
      `CHK("ot_boost", 1'h0, boost_en)
      `CHK("ot_ldo", 1'h0, ldo_en)
      oh = 1'h0;
      cyc(5);
      `CHK("ot_lvl", m ? 4'h0 : 4'h5, output_level_bits)
      `CHK("ot_ldo2", m ? 1'h0 : 1'h1, ldo_en)
      `CHK("ot_hold", 1'h1, diag_status.overheat_flag)
      u_host.read_stat();
      cyc(2);
      `CHK("ot_clr", 1'h0, diag_status.overheat_flag)
    end
    $display("test overheat done");
    // Static clamp start, level bits cleared under restart mode one.
    w = {4'h9, 2'h0, 1'h1, 1'h1, 1'h0};
    u_host.write_cfg(w);
    ol = 1'h1;
    cyc(ON_T + 10);
    `CHK("st_flag", 1'h1, diag_status.overload_flag)
    `CHK("st_ldo", 1'h1, ldo_en)
    ol = 1'h0;
    cyc(5);
    `CHK("st_lvl", 4'h0, output_level_bits)
    u_host.read_stat();
    cyc(2);
    `CHK("st_clr", 1'h0, diag_status.overload_flag)
    $display("test static done");
    // Pulsed cycle with a persisting overload, automatic restart.
    w = {4'h9, 5'h00};
    u_host.write_cfg(w);
    ol = 1'h1;
    cyc(ON_T - 8);
    `CHK("pl_on", 1'h1, ldo_en)
    `CHK("pl_noflag", 1'h0, diag_status.overload_flag)
    cyc(16);
    `CHK("pl_off", 1'h0, ldo_en)
    `CHK("pl_flag", 1'h1, diag_status.overload_flag)
    cyc(40);
    `CHK("pl_still", 1'h0, ldo_en)
    cyc(20);
    `CHK("pl_retry", 1'h1, ldo_en)
    cyc(15);
    `CHK("pl_again", 1'h0, ldo_en)
    ol = 1'h0;
    cyc(80);
    `CHK("pl_norm", 1'h1, ldo_en)
    cyc(40);
    `CHK("pl_stay", 1'h1, ldo_en)
    `CHK("pl_hold", 1'h1, diag_status.overload_flag)
    u_host.read_stat();
    cyc(2);
    `CHK("pl_clr", 1'h0, diag_status.overload_flag)
    $display("test pulsed done");
    // Lockout clears the control register and refuses writes.
    uv = 1'h1;
    cyc(5);
    `CHK("uv_cfg", 9'h000, cfg_q)
    `CHK("uv_rdy", 1'h0, serial_ready)
    `CHK("uv_ldo", 1'h0, ldo_en)
    u_host.write_cfg(w);
    cyc(2);
    `CHK("uv_drop", 9'h000, cfg_q)
    uv = 1'h0;
    cyc(5);
    `CHK("uv_rdy2", 1'h1, serial_ready)
    u_host.write_cfg(w);
    cyc(1);
    `CHK("uv_wr", w, cfg_q)
    $display("test lockout done");
    // Envelope tone delays, continuous tone and external wave.
    w = {4'h3, 1'h0, 1'h1, 3'h0};
    u_host.write_cfg(w);
    u_host.set_env(1'h1);
    cyc(TONE_ON_CYC - 20);
    `CHK("tn_early", 1'h0, tone_out_en)
    cyc(40);
    `CHK("tn_on", 1'h1, tone_out_en)
    u_host.set_env(1'h0);
    cyc(TONE_OFF_CYC - 20);
    `CHK("tn_hold", 1'h1, tone_out_en)
    cyc(40);
    `CHK("tn_off", 1'h0, tone_out_en)
    u_host.set_env(1'h1);
    cyc(TONE_ON_CYC + 20);
    w.tone_on_bit = 1'h0;
    u_host.write_cfg(w);
    cyc(2);
    `CHK("tn_bit", 1'h0, tone_out_en)
    w.tone_on_bit = 1'h1;
    w.external_tone_select = 1'h1;
    u_host.write_cfg(w);
    u_host.set_env(1'h0);
    cyc(5);
    `CHK("tn_ext0", 1'h0, tone_out_en)
    u_host.set_env(1'h1);
    cyc(5);
    `CHK("tn_ext1", 1'h1, tone_out_en)
    $display("test tone done");
    wrap_up();
  end
endmodule
